// *** mhf_pkg.sv ***
// Constants, types and helpers of the host interface front end
// Functional notes
// RULE1 - Two straps pick 80-parallel, 68-parallel, 4-wire or 3-wire serial host link
// RULE2 - Straps stay fixed; the host link never changes while running
// RULE3 - Parallel width is 8/9/12/16/18/24 bits from the format code, low pins up
// RULE4 - Above 8 bits, upper bits are dropped for commands and parameters
// RULE5 - Host drives unused upper bits to a defined level during commands
// RULE6 - 80-style write is select low with write low; read likewise
// RULE7 - Host never asserts read and write strobes together in 80-style mode
// RULE8 - 80-style write data is taken at the write strobe rising edge
// RULE9 - 80-style bus is driven while read strobe is low and selected
// RULE10 - Command/data select low means command, high means parameter or data
// RULE11 - Parallel data pins float whenever chip select is high
// RULE12 - 68-style write is select low, enable high, direction low; latch at enable rise (code takes the data when the enable falls)
// RULE13 - 68-style read drives bus while enable high, select low, direction high
// RULE14 - 68-style direction low is write, high is read
// RULE15 - Any read strobe condition enters read state and may output dummy data
// RULE16 - Host keeps command/data select high during a read pulse
// RULE17 - Read seeing select low gives dummy data until a new command
// RULE18 - Command/data select is ignored while no read pulse is active (code also samples it during write strobes and serial clock rises)
// RULE19 - Serial data sampled on clock rise, driven while clock low on reads
// RULE20 - Serial data line floats whenever chip select is high
// RULE21 - Bank select routes low byte and serial data to high or low bank
// RULE22 - External sync frame starts on falling edge of frame sync input
// RULE23 - Data bus floats while the hardware reset pin is low
// RULE24 - With chip select high, select, read and write strobes are ignored
// RULE25 - Serial modes always use an 8-bit data path
// RULE26 - Strobes are synchronised so each strobe gives one internal transfer
package mhf_pkg;
    typedef enum logic [1:0] {
        MHF_P80 = 2'h0,
        MHF_P68 = 2'h1,
        MHF_S4 = 2'h2,
        MHF_S3 = 2'h3
    } mhf_mode_e;

    typedef enum logic [1:0] {
        MHF_IDLE = 2'h0,
        MHF_WRITE = 2'h1,
        MHF_READ = 2'h2
    } mhf_pstate_e;

    // Bus width codes of the format command
    localparam logic [2:0] MHF_W8 = 3'h0;
    localparam logic [2:0] MHF_W9 = 3'h1;
    localparam logic [2:0] MHF_W12 = 3'h2;
    localparam logic [2:0] MHF_W16 = 3'h3;
    localparam logic [2:0] MHF_W18 = 3'h4;
    localparam logic [2:0] MHF_W24 = 3'h5;

    localparam logic [23:0] MHF_DUMMY = 24'h00_0000;
    localparam logic [23:0] MHF_DATA_RST = 24'h00_0000;
    localparam logic [7:0] MHF_BYTE_RST = 8'h00;

    // Synchroniser bit positions
    localparam int MHF_SYNC_W = 43;
    localparam int MHF_P_HD = 0;
    localparam int MHF_P_LV = 24;
    localparam int MHF_P_FS = 32;
    localparam int MHF_P_LVSD = 33;
    localparam int MHF_P_HVSD = 34;
    localparam int MHF_P_WR = 35;
    localparam int MHF_P_RD = 36;
    localparam int MHF_P_A0 = 37;
    localparam int MHF_P_CS = 38;
    localparam int MHF_P_HWR = 39;
    localparam int MHF_P_IOB = 40;
    localparam int MHF_P_FAM = 41;
    localparam int MHF_P_PS = 42;
    // Idle levels: strobes, select and frame sync high, reset pin low
    localparam logic [42:0] MHF_SYNC_RST = 43'h059_0000_0000;

    // Cycles after reset release during which the straps are taken, then frozen
    localparam logic [1:0] MHF_STRAP_CNT = 2'h3;
    localparam logic [3:0] MHF_SER4_BITS = 4'h8;
    localparam logic [3:0] MHF_SER3_BITS = 4'h9;

    function automatic logic [23:0] mhf_width_mask(input logic [2:0] w);
        case (w)
            MHF_W8: return 24'h00_00ff;
            MHF_W9: return 24'h00_01ff;
            MHF_W12: return 24'h00_0fff;
            MHF_W16: return 24'h00_ffff;
            MHF_W18: return 24'h03_ffff;
            default: return 24'hff_ffff;
        endcase
    endfunction
endpackage

// *** mhf_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module mhf_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input logic clk,
    input logic sys_rst,
    input logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta <= RST;
            q <= RST;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// *** mhf_frontend.sv ***
// Host interface front end: strap decode, strobes, serial and bus drive
`timescale 1ns/1ps
module mhf_frontend (
    input logic clk,
    input logic sys_rst,
    input logic parallel_serial_select,
    input logic bus_family_select,
    input logic io_bank_select,
    input logic hw_reset_n,
    input logic chip_select_n,
    input logic cmd_data_select,
    input logic read_strobe_n,
    input logic write_strobe_n,
    input logic [23:0] host_data_in,
    input logic [7:0] lv_data_in,
    input logic hv_serial_in,
    input logic lv_serial_in,
    input logic frame_sync_input,
    input logic [2:0] interface_format_command,
    input logic display_data_phase,
    input logic external_sync_enable_cmd,
    input logic serial_read_en,
    input logic [23:0] read_data,
    input logic read_data_valid,
    output mhf_pkg::mhf_mode_e host_mode,
    output logic [23:0] host_data_out,
    output logic host_upper_oe_n,
    output logic host_low_oe_n,
    output logic [7:0] lv_data_out,
    output logic lv_data_oe_n,
    output logic hv_serial_out,
    output logic hv_serial_oe_n,
    output logic lv_serial_out,
    output logic lv_serial_oe_n,
    output logic xfer_valid,
    output logic xfer_is_cmd,
    output logic [23:0] xfer_data,
    output logic read_pulse,
    output logic read_dummy,
    output logic frame_start
);
    import mhf_pkg::*;

    logic [42:0] pins_raw;
    logic [42:0] pins_s;
    logic ps_s, fam_s, iob_s, hwr_s, cs_s, a0_s, rd_s, wr_s;
    logic hvsd_s, lvsd_s, fs_s;
    logic [23:0] hd_s;
    logic [7:0] lv_s;

    assign pins_raw = {parallel_serial_select, bus_family_select,
        io_bank_select, hw_reset_n, chip_select_n, cmd_data_select,
        read_strobe_n, write_strobe_n, hv_serial_in, lv_serial_in,
        frame_sync_input, lv_data_in, host_data_in};

    // All pins cross into clk before any use
    mhf_sync #(.W(MHF_SYNC_W), .RST(MHF_SYNC_RST)) u_sync ( // RULE26
        .clk(clk),
        .sys_rst(sys_rst),
        .d(pins_raw),
        .q(pins_s)
    );

    assign ps_s = pins_s[MHF_P_PS];
    assign fam_s = pins_s[MHF_P_FAM];
    assign iob_s = pins_s[MHF_P_IOB];
    assign hwr_s = pins_s[MHF_P_HWR];
    assign cs_s = pins_s[MHF_P_CS];
    assign a0_s = pins_s[MHF_P_A0];
    assign rd_s = pins_s[MHF_P_RD];
    assign wr_s = pins_s[MHF_P_WR];
    assign hvsd_s = pins_s[MHF_P_HVSD];
    assign lvsd_s = pins_s[MHF_P_LVSD];
    assign fs_s = pins_s[MHF_P_FS];
    assign lv_s = pins_s[MHF_P_LV +: 8];
    assign hd_s = pins_s[MHF_P_HD +: 24];

    // Strap capture, frozen once taken
    logic [1:0] strap_cnt, next_strap_cnt;
    mhf_mode_e strap_mode, next_host_mode;
    logic strap_done;

    assign strap_mode = mhf_mode_e'({~ps_s, ~(ps_s ^ fam_s)}); // RULE1
    assign strap_done = (strap_cnt == MHF_STRAP_CNT);

    always_comb
    begin
        next_strap_cnt = strap_cnt;
        next_host_mode = host_mode;
        if (!strap_done) // RULE2
        begin
            next_strap_cnt = strap_cnt + 2'h1;
            next_host_mode = strap_mode;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strap_cnt <= 2'h0;
            host_mode <= MHF_P80;
        end
        else
        begin
            strap_cnt <= next_strap_cnt;
            host_mode <= next_host_mode;
        end
    end

    // Strobe decode
    logic hw_ok, sel, par, ser, wr_act, rd_act, sclk, sd_in, rise, fall;
    logic [23:0] par_in, wmask, rd_src;
    logic [3:0] nbits;

    assign hw_ok = hwr_s & strap_done; // RULE23
    assign sel = hw_ok & ~cs_s; // RULE24
    assign par = ~host_mode[1];
    assign ser = host_mode[1];
    assign wr_act = sel & par & ((host_mode == MHF_P80) ? ~wr_s // RULE6
        : (rd_s & ~wr_s)); // RULE12 RULE14
    assign rd_act = sel & par & ((host_mode == MHF_P80) ? ~rd_s // RULE6
        : (rd_s & wr_s)); // RULE13 RULE14
    assign sclk = (host_mode == MHF_S4) ? wr_s : a0_s; // RULE19
    assign sd_in = iob_s ? hvsd_s : lvsd_s; // RULE21
    assign par_in = {hd_s[23:8], iob_s ? hd_s[7:0] : lv_s}; // RULE21
    assign wmask = mhf_width_mask(interface_format_command); // RULE3
    assign rd_src = (read_dummy | ~read_data_valid) ? MHF_DUMMY // RULE15
        : (read_data & wmask);
    assign nbits = (host_mode == MHF_S3) ? MHF_SER3_BITS : MHF_SER4_BITS;

    // Transfer state
    mhf_pstate_e pstate, next_pstate;
    logic [23:0] wr_lat, next_wr_lat, next_xfer_data, next_host_data_out;
    logic a0_lat, next_a0_lat, next_xfer_valid, next_xfer_is_cmd;
    logic next_read_pulse, next_read_dummy, next_frame_start;
    logic [8:0] rx_sh, next_rx_sh;
    logic [3:0] rx_cnt, next_rx_cnt;
    logic sclk_d, next_sclk_d, fs_d, next_fs_d;
    logic next_upper_oe_n, next_low_oe_n, next_lv_oe_n;
    logic [7:0] next_lv_data_out;

    assign rise = sel & ser & sclk & ~sclk_d;
    assign fall = sel & ser & ~sclk & sclk_d;

    always_comb
    begin
        next_pstate = pstate;
        next_wr_lat = wr_lat;
        next_a0_lat = a0_lat;
        next_xfer_valid = 1'b0;
        next_xfer_is_cmd = xfer_is_cmd;
        next_xfer_data = xfer_data;
        next_read_pulse = 1'b0;
        next_read_dummy = read_dummy;
        next_rx_sh = rx_sh;
        next_rx_cnt = rx_cnt;
        next_sclk_d = sclk;
        next_fs_d = fs_s;
        next_frame_start = external_sync_enable_cmd & fs_d & ~fs_s; // RULE22
        // Select sampled only with a strobe active or on a serial clock rise
        if (wr_act) // RULE18
        begin
            next_wr_lat = par_in;
            next_a0_lat = a0_s;
        end
        case (pstate)
            MHF_IDLE:
            begin
                if (wr_act)
                    next_pstate = MHF_WRITE;
                else if (rd_act) // RULE15
                begin
                    next_pstate = MHF_READ;
                    next_read_pulse = 1'b1;
                    if (!a0_s)
                        next_read_dummy = 1'b1; // RULE17
                end
            end
            MHF_WRITE:
            begin
                if (!wr_act) // RULE8 RULE12
                begin
                    next_pstate = MHF_IDLE;
                    next_xfer_valid = 1'b1;
                    next_xfer_is_cmd = ~a0_lat; // RULE10
                    if (!a0_lat || !display_data_phase)
                        next_xfer_data = {16'h0000, wr_lat[7:0]}; // RULE4
                    else
                        next_xfer_data = wr_lat & wmask; // RULE3
                    if (!a0_lat)
                        next_read_dummy = 1'b0; // RULE17
                end
            end
            MHF_READ:
            begin
                if (!rd_act)
                    next_pstate = MHF_IDLE;
            end
            default:
                next_pstate = MHF_IDLE;
        endcase
        if (!sel || !ser)
            next_rx_cnt = 4'h0;
        else if (rise && !serial_read_en) // RULE19
        begin
            next_rx_sh = {rx_sh[7:0], sd_in};
            next_rx_cnt = rx_cnt + 4'h1;
            if (next_rx_cnt == nbits)
            begin
                next_rx_cnt = 4'h0;
                next_xfer_valid = 1'b1;
                next_xfer_data = {16'h0000, rx_sh[6:0], sd_in}; // RULE25
                if (host_mode == MHF_S3)
                    next_xfer_is_cmd = ~rx_sh[7];
                else
                    next_xfer_is_cmd = ~a0_s; // RULE10
            end
        end
        next_upper_oe_n = ~(par & rd_act); // RULE9 RULE11 RULE13
        next_low_oe_n = ~(par & rd_act & iob_s); // RULE21
        next_lv_oe_n = ~(par & rd_act & ~iob_s); // RULE21
        next_host_data_out = {rd_src[23:8],
            iob_s ? rd_src[7:0] : MHF_BYTE_RST};
        next_lv_data_out = rd_src[7:0];
        if (!hw_ok) // RULE23
        begin
            next_pstate = MHF_IDLE;
            next_read_dummy = 1'b0;
            next_rx_cnt = 4'h0;
            next_xfer_valid = 1'b0;
            next_read_pulse = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pstate <= MHF_IDLE;
            wr_lat <= MHF_DATA_RST;
            a0_lat <= 1'b1;
            xfer_valid <= 1'b0;
            xfer_is_cmd <= 1'b0;
            xfer_data <= MHF_DATA_RST;
            read_pulse <= 1'b0;
            read_dummy <= 1'b0;
            rx_sh <= 9'h000;
            rx_cnt <= 4'h0;
            sclk_d <= 1'b1;
            fs_d <= 1'b1;
            frame_start <= 1'b0;
            host_upper_oe_n <= 1'b1;
            host_low_oe_n <= 1'b1;
            lv_data_oe_n <= 1'b1;
            host_data_out <= MHF_DATA_RST;
            lv_data_out <= MHF_BYTE_RST;
        end
        else
        begin
            pstate <= next_pstate;
            wr_lat <= next_wr_lat;
            a0_lat <= next_a0_lat;
            xfer_valid <= next_xfer_valid;
            xfer_is_cmd <= next_xfer_is_cmd;
            xfer_data <= next_xfer_data;
            read_pulse <= next_read_pulse;
            read_dummy <= next_read_dummy;
            rx_sh <= next_rx_sh;
            rx_cnt <= next_rx_cnt;
            sclk_d <= next_sclk_d;
            fs_d <= next_fs_d;
            frame_start <= next_frame_start;
            host_upper_oe_n <= next_upper_oe_n;
            host_low_oe_n <= next_low_oe_n;
            lv_data_oe_n <= next_lv_oe_n;
            host_data_out <= next_host_data_out;
            lv_data_out <= next_lv_data_out;
        end
    end

    // Serial read-back shifter
    logic [7:0] tx_sh, next_tx_sh;
    logic [2:0] tx_cnt, next_tx_cnt;
    logic next_sd_bit, sd_drive;

    assign sd_drive = sel & ser & serial_read_en & ~sclk; // RULE19 RULE20

    always_comb
    begin
        next_tx_sh = tx_sh;
        next_tx_cnt = tx_cnt;
        next_sd_bit = hv_serial_out;
        if (!sel || !ser || !serial_read_en)
            next_tx_cnt = 3'h0;
        else if (fall)
        begin
            next_tx_cnt = tx_cnt + 3'h1;
            if (tx_cnt == 3'h0)
            begin
                next_sd_bit = rd_src[7]; // RULE25
                next_tx_sh = {rd_src[6:0], 1'b0};
            end
            else
            begin
                next_sd_bit = tx_sh[7];
                next_tx_sh = {tx_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_sh <= MHF_BYTE_RST;
            tx_cnt <= 3'h0;
            hv_serial_out <= 1'b0;
            lv_serial_out <= 1'b0;
            hv_serial_oe_n <= 1'b1;
            lv_serial_oe_n <= 1'b1;
        end
        else
        begin
            tx_sh <= next_tx_sh;
            tx_cnt <= next_tx_cnt;
            hv_serial_out <= next_sd_bit;
            lv_serial_out <= next_sd_bit;
            hv_serial_oe_n <= ~(sd_drive & iob_s); // RULE21
            lv_serial_oe_n <= ~(sd_drive & ~iob_s); // RULE21
        end
    end

    // Checks
    sequence s_write_end;
        (pstate == MHF_WRITE) ##1 (pstate == MHF_IDLE);
    endsequence

    sequence s_read_cmd_low;
        (pstate == MHF_IDLE) && !wr_act && rd_act && !a0_s;
    endsequence

    AST_STRAP_TAKE: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        (strap_cnt == 2'h1) |=> (host_mode == $past(strap_mode)))
        else $error("mode not taken from straps");
    AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
        strap_done |=> $stable(host_mode))
        else $error("mode changed after capture");
    AST_CMD_LOW_BYTE: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
        (xfer_valid && xfer_is_cmd) |-> (xfer_data[23:8] == 16'h0000))
        else $error("upper bits kept on command");
    AST_WRITE_XFER: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
        s_write_end |-> xfer_valid)
        else $error("no transfer at write end");
    AST_READ_DRIVE: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
        (par && rd_act) |=> !host_upper_oe_n)
        else $error("bus not driven during read");
    AST_CS_FLOAT: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
        cs_s |=> (host_upper_oe_n && host_low_oe_n && lv_data_oe_n))
        else $error("bus driven while deselected");
    AST_DUMMY_SET: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
        (hw_ok and s_read_cmd_low) |=> (read_dummy && read_pulse))
        else $error("dummy mode not entered");
    AST_SD_FLOAT: assert property (@(posedge clk) disable iff (sys_rst) // RULE20
        (ser && cs_s) |=> (hv_serial_oe_n && lv_serial_oe_n))
        else $error("serial line driven while deselected");
    AST_HWRST_FLOAT: assert property (@(posedge clk) disable iff (sys_rst) // RULE23
        !hwr_s |=> (host_upper_oe_n && lv_data_oe_n && hv_serial_oe_n))
        else $error("pins driven in hardware reset");
    AST_FRAME_EDGE: assert property (@(posedge clk) disable iff (sys_rst) // RULE22
        (external_sync_enable_cmd && fs_d && !fs_s) |=> frame_start)
        else $error("frame start missed");
    AST_ONE_XFER: assert property (@(posedge clk) disable iff (sys_rst) // RULE26
        xfer_valid |=> !xfer_valid)
        else $error("transfer pulse longer than one cycle");
endmodule

// *** mhf_host.sv ***
// Host processor model driving the front end's parallel and serial pins
`timescale 1ns/1ps
module mhf_host (
    input wire logic clk,
    input wire logic p68,
    input wire logic bank_hv,
    output logic cs_n,
    output logic a0,
    output logic rd_n,
    output logic wr_n,
    output logic [23:0] data,
    output logic hv_sd,
    output logic lv_sd
);
    logic sd;
    // Unselected bank carries the inverted copy
    assign hv_sd = bank_hv ? sd : ~sd;
    assign lv_sd = bank_hv ? ~sd : sd;
    initial
    begin
        cs_n = 1'b1;
        a0 = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        data = 24'h00_0000;
        sd = 1'b0;
    end
    // Write: 80 strobe low, or 68 enable high with direction low
    task automatic wr(input logic cs, input logic c, input logic [23:0] d);
        @(negedge clk);
        cs_n = cs;
        a0 = c;
        data = d;
        rd_n = 1'b1;
        wr_n = 1'b0;
        repeat (3) @(negedge clk);
        if (p68)
            rd_n = 1'b0;
        else
            wr_n = 1'b1;
    endtask
    // Read start; select held steady until the strobe ends
    task automatic rd_on(input logic cs, input logic c);
        @(negedge clk);
        cs_n = cs;
        a0 = c;
        wr_n = 1'b1;
        rd_n = p68;
    endtask
    task automatic rd_off();
        @(negedge clk);
        rd_n = ~p68;
    endtask
    // Serial frame, MSB first; clock idles high between frames
    task automatic ser(input logic three, input logic c, input logic [7:0] b);
        logic [8:0] v;
        int n;
        v = three ? {c, b} : {b, 1'b0};
        n = three ? 9 : 8;
        @(negedge clk);
        a0 = three ? 1'b1 : c;
        wr_n = 1'b1;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sd = v[8-i];
            if (three)
                a0 = 1'b0;
            else
                wr_n = 1'b0;
            repeat (2) @(negedge clk);
            if (three)
                a0 = 1'b1;
            else
                wr_n = 1'b1;
            repeat (2) @(negedge clk);
        end
    endtask
    task automatic desel();
        @(negedge clk);
        cs_n = 1'b1;
        sd = ~sd;
    endtask
endmodule

// *** tb_mhf_frontend.sv ***
// Testbench of the host interface front end
`timescale 1ns/1ps
module tb_mhf_frontend;
    import mhf_pkg::*;
    localparam logic [23:0] MASKS [6] = '{24'h00_00ff, 24'h00_01ff,
        24'h00_0fff, 24'h00_ffff, 24'h03_ffff, 24'hff_ffff};
    logic clk, sys_rst, parallel_serial_select, bus_family_select;
    logic io_bank_select, hw_reset_n, chip_select_n, cmd_data_select;
    logic read_strobe_n, write_strobe_n, hv_serial_in, lv_serial_in;
    logic frame_sync_input, display_data_phase, external_sync_enable_cmd;
    logic serial_read_en, read_data_valid, host_upper_oe_n, host_low_oe_n;
    logic lv_data_oe_n, hv_serial_out, hv_serial_oe_n, lv_serial_out;
    logic lv_serial_oe_n, xfer_valid, xfer_is_cmd, read_pulse, read_dummy;
    logic frame_start, h_hsd, h_lsd, p68, seen;
    logic [23:0] host_data_in, read_data, host_data_out, xfer_data, h_d;
    logic [7:0] lv_data_in, lv_data_out;
    logic [2:0] interface_format_command;
    mhf_mode_e host_mode;
    int error_cnt = 0;
    int cmp_count = 0;
    assign p68 = parallel_serial_select & bus_family_select;
    assign host_data_in[23:8] = host_upper_oe_n ? h_d[23:8]
        : host_data_out[23:8];
    assign host_data_in[7:0] = !host_low_oe_n ? host_data_out[7:0]
        : (io_bank_select ? h_d[7:0] : ~h_d[7:0]);
    assign lv_data_in = !lv_data_oe_n ? lv_data_out
        : (io_bank_select ? ~h_d[7:0] : h_d[7:0]);
    assign hv_serial_in = !hv_serial_oe_n ? hv_serial_out : h_hsd;
    assign lv_serial_in = !lv_serial_oe_n ? lv_serial_out : h_lsd;

    mhf_frontend uut (.clk, .sys_rst, .parallel_serial_select,
        .bus_family_select, .io_bank_select, .hw_reset_n, .chip_select_n,
        .cmd_data_select, .read_strobe_n, .write_strobe_n, .host_data_in,
        .lv_data_in, .hv_serial_in, .lv_serial_in, .frame_sync_input,
        .interface_format_command, .display_data_phase,
        .external_sync_enable_cmd, .serial_read_en, .read_data,
        .read_data_valid, .host_mode, .host_data_out, .host_upper_oe_n,
        .host_low_oe_n, .lv_data_out, .lv_data_oe_n, .hv_serial_out,
        .hv_serial_oe_n, .lv_serial_out, .lv_serial_oe_n, .xfer_valid,
        .xfer_is_cmd, .xfer_data, .read_pulse, .read_dummy, .frame_start);
    mhf_host host (.clk, .p68, .bank_hv(io_bank_select),
        .cs_n(chip_select_n), .a0(cmd_data_select), .rd_n(read_strobe_n),
        .wr_n(write_strobe_n), .data(h_d), .hv_sd(h_hsd), .lv_sd(h_lsd));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Wait for one completed transfer, then compare its kind and word
    task automatic wait_x(input logic c, input logic [23:0] d);
        int k;
        k = 0;
        while (xfer_valid !== 1'b1 && k < 10)
        begin
            @(negedge clk);
            k++;
        end
        chk(24'(k < 10), 24'h00_0001);
        chk(24'(xfer_is_cmd), 24'(c));
        chk(xfer_data, d);
    endtask
    task automatic do_reset(input logic p, input logic f);
        host.desel();
        @(negedge clk);
        parallel_serial_select = p;
        bus_family_select = f;
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #(40 * 5000);
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        sys_rst = 1'b1;
        parallel_serial_select = 1'b1;
        bus_family_select = 1'b0;
        io_bank_select = 1'b1;
        hw_reset_n = 1'b1;
        frame_sync_input = 1'b1;
        interface_format_command = MHF_W24;
        display_data_phase = 1'b0;
        external_sync_enable_cmd = 1'b0;
        serial_read_en = 1'b0;
        read_data = 24'h12_3456;
        read_data_valid = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            io_bank_select = 1'b1;
            display_data_phase = 1'b0;
            interface_format_command = MHF_W24;
            do_reset(~i[1], i[0] ^ i[1]);
            chk(24'(host_mode), 24'(i));
            chk(24'({host_upper_oe_n, host_low_oe_n, lv_data_oe_n,
                hv_serial_oe_n, lv_serial_oe_n}), 24'h00_001f);
            case (i)
                0:
                begin
                    host.wr(1'b0, 1'b0, 24'hAB_CD12);
                    wait_x(1'b1, 24'h00_0012);
                    display_data_phase = 1'b1;
                    for (int w = 0; w < 6; w++)
                    begin
                        interface_format_command = 3'(w);
                        host.wr(1'b0, 1'b1, 24'hFF_FFFF);
                        wait_x(1'b0, MASKS[w]);
                    end
                    seen = 1'b0;
                    host.wr(1'b1, 1'b0, 24'h00_0077);
                    repeat (8) @(negedge clk) seen = seen | xfer_valid;
                    chk(24'(seen), 24'h00_0000);
                    host.rd_on(1'b1, 1'b1);
                    repeat (5) @(negedge clk);
                    chk(24'({host_upper_oe_n, host_low_oe_n}), 24'h3);
                    host.rd_off();
                    host.rd_on(1'b0, 1'b1);
                    repeat (5) @(negedge clk);
                    chk(host_data_out, 24'h12_3456);
                    chk(24'({host_upper_oe_n, host_low_oe_n}), 24'h0);
                    hw_reset_n = 1'b0;
                    repeat (4) @(negedge clk);
                    chk(24'({host_upper_oe_n, host_low_oe_n}), 24'h3);
                    host.rd_off();
                    hw_reset_n = 1'b1;
                    repeat (4) @(negedge clk);
                    host.rd_on(1'b0, 1'b0);
                    repeat (5) @(negedge clk);
                    chk(host_data_out, MHF_DUMMY);
                    host.rd_off();
                    repeat (3) @(negedge clk);
                    host.rd_on(1'b0, 1'b1);
                    repeat (5) @(negedge clk);
                    chk(host_data_out, MHF_DUMMY);
                    chk(24'(read_dummy), 24'h00_0001);
                    host.rd_off();
                    repeat (3) @(negedge clk);
                    host.wr(1'b0, 1'b0, 24'h00_0029);
                    wait_x(1'b1, 24'h00_0029);
                    chk(24'(read_dummy), 24'h00_0000);
                    io_bank_select = 1'b0;
                    display_data_phase = 1'b0;
                    host.wr(1'b0, 1'b1, 24'hFF_FF55);
                    wait_x(1'b0, 24'h00_0055);
                    host.rd_on(1'b0, 1'b1);
                    repeat (5) @(negedge clk);
                    chk(24'({lv_data_oe_n, lv_data_out}), 24'h00_0056);
                    host.rd_off();
                    external_sync_enable_cmd = 1'b1;
                    frame_sync_input = 1'b0;
                    seen = 1'b0;
                    repeat (8) @(negedge clk) seen = seen | frame_start;
                    chk(24'(seen), 24'h00_0001);
                    frame_sync_input = 1'b1;
                end
                1:
                begin
                    interface_format_command = MHF_W16;
                    display_data_phase = 1'b1;
                    host.wr(1'b0, 1'b1, 24'hAB_CDEF);
                    wait_x(1'b0, 24'h00_CDEF);
                    host.rd_on(1'b0, 1'b1);
                    repeat (5) @(negedge clk);
                    chk(host_data_out, 24'h00_3456);
                    host.rd_off();
                end
                default:
                begin
                    io_bank_select = i[0];
                    host.ser(i[0], 1'b1, 8'hA5);
                    wait_x(1'b0, 24'h00_00A5);
                    host.desel();
                    host.ser(i[0], 1'b0, 8'h3C);
                    wait_x(1'b1, 24'h00_003C);
                    host.desel();
                end
            endcase
            $display("Mode %0d tests done, mismatches %0d", i, error_cnt);
        end
        print_verdict();
    end
endmodule
